// ===== include/wpc_pkg.sv
package wpc_pkg;
  // register map, byte addresses on the avalon slave
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hC;
  // control register fields
  localparam int PS_LSB = 1;
  localparam int PS_MSB = 5;
  localparam int EN_BIT = 0;
  localparam logic [4:0] PS_RESET = 5'h0b;
  localparam logic EN_RESET = 1'b0;
  localparam logic [4:0] PS_MAX_CODE = 5'h12;
  localparam int BASE_SHIFT = 5;
  localparam int CNT_W = 24;
  // configuration mode encodings
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_SW = 2'h1;
  // status bit positions
  localparam int ST_TIMEOUT = 0;
  // oscillator tick: 31 kHz source, one tick per 1/31 ms nominal
  localparam int OSC_HZ = 31000;
  localparam int CLK_HZ = 10000000;
  localparam int TICK_DIV = CLK_HZ / OSC_HZ;

  typedef struct packed {
    logic [4:0] period_select;
    logic software_watchdog_enable;
  } wpc_ctrl_t;

  typedef struct packed {
    wpc_ctrl_t ctrl;
    logic [CNT_W-1:0] count;
    logic [8:0] osc_div;
    logic osc_tick;
    logic status;
    logic mask;
    logic irq;
    logic timeout;
    logic waitreq;
    logic [31:0] rdata;
  } wpc_state_t;
endpackage

// ===== hdl/wpc_top.sv
`timescale 1ns/1ns
module wpc_top #(
  parameter int TICK_DIV = wpc_pkg::TICK_DIV
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [1:0] watchdog_config_mode,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic watchdog_timeout,
  output logic irq
);
  wpc_pkg::wpc_state_t s_r;
  wpc_pkg::wpc_state_t s_nxt;
  logic active;
  logic [wpc_pkg::CNT_W:0] ratio;

  // mode 00 forces off; modes 10/11 run regardless of enable
  always_comb begin
    case (watchdog_config_mode)
      wpc_pkg::MODE_OFF: active = 1'b0;
      wpc_pkg::MODE_SW: active = s_r.ctrl.software_watchdog_enable;
      default: active = 1'b1;
    endcase
  end

  // prescale ratio as a power of two; reserved codes fall back to 1:32
  always_comb begin
    if (s_r.ctrl.period_select > wpc_pkg::PS_MAX_CODE) begin
      ratio = (wpc_pkg::CNT_W+1)'(1) << wpc_pkg::BASE_SHIFT;
    end else begin
      ratio = (wpc_pkg::CNT_W+1)'(1) << (s_r.ctrl.period_select + 5'd5);
    end
  end

  always_comb begin
    logic acc;
    logic wr_ctrl;
    acc = 1'b0;
    wr_ctrl = 1'b0;
    s_nxt = s_r;
    s_nxt.timeout = 1'b0;
    // free running divider stands in for the 31 kHz oscillator tick
    if (s_r.osc_div >= 9'(TICK_DIV - 1)) begin
      s_nxt.osc_div = 9'h000;
      s_nxt.osc_tick = 1'b1;
    end else begin
      s_nxt.osc_div = s_r.osc_div + 9'h001;
      s_nxt.osc_tick = 1'b0;
    end
    // one wait cycle per access keeps readdata registered
    acc = (avs_read || avs_write) && s_r.waitreq;
    s_nxt.waitreq = !(avs_read || avs_write) ? 1'b1 : !s_r.waitreq;
    if (acc && avs_write) begin
      case (avs_address)
        wpc_pkg::ADDR_CONTROL: begin
          wr_ctrl = 1'b1;
          s_nxt.ctrl.period_select = avs_writedata[wpc_pkg::PS_MSB:wpc_pkg::PS_LSB];
          s_nxt.ctrl.software_watchdog_enable = avs_writedata[wpc_pkg::EN_BIT];
        end
        wpc_pkg::ADDR_STATUS: begin
          if (avs_writedata[wpc_pkg::ST_TIMEOUT]) begin
            s_nxt.status = 1'b0;
          end
        end
        wpc_pkg::ADDR_MASK: s_nxt.mask = avs_writedata[wpc_pkg::ST_TIMEOUT];
        default: ;
      endcase
    end
    if (acc && avs_read) begin
      case (avs_address)
        wpc_pkg::ADDR_CONTROL:
          s_nxt.rdata = {26'h000_0000, s_r.ctrl.period_select,
                         s_r.ctrl.software_watchdog_enable};
        wpc_pkg::ADDR_STATUS: s_nxt.rdata = {31'h0000_0000, s_r.status};
        wpc_pkg::ADDR_MASK: s_nxt.rdata = {31'h0000_0000, s_r.mask};
        wpc_pkg::ADDR_COUNT: s_nxt.rdata = {8'h00, s_r.count};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    // disabled watchdog stays cleared; a period change restarts the count
    if (!active || wr_ctrl) begin
      s_nxt.count = '0;
    end else if (s_r.osc_tick) begin
      if ({1'b0, s_r.count} + (wpc_pkg::CNT_W+1)'(1) >= ratio) begin
        s_nxt.count = '0;
        s_nxt.timeout = 1'b1;
      end else begin
        s_nxt.count = s_r.count + wpc_pkg::CNT_W'(1);
      end
    end
    // set wins over a clear in the same cycle
    if (s_nxt.timeout) begin
      s_nxt.status = 1'b1;
    end
    s_nxt.irq = s_nxt.status && s_nxt.mask;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.ctrl.period_select <= wpc_pkg::PS_RESET;
      s_r.ctrl.software_watchdog_enable <= wpc_pkg::EN_RESET;
      s_r.waitreq <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign avs_readdata = s_r.rdata;
  assign avs_waitrequest = s_r.waitreq;
  assign watchdog_timeout = s_r.timeout;
  assign irq = s_r.irq;

  a_reset_period: assert property (@(posedge clk_sys) $fell(reset) |->
    s_r.ctrl.period_select == 5'h0b && !s_r.ctrl.software_watchdog_enable)
    else $error("reset values wrong");
  a_off_mode: assert property (@(posedge clk_sys) disable iff (reset)
    watchdog_config_mode == 2'h0 |=> s_r.count == '0)
    else $error("counter runs in off mode");
  a_sw_disabled: assert property (@(posedge clk_sys) disable iff (reset)
    watchdog_config_mode == 2'h1 && !s_r.ctrl.software_watchdog_enable |=> !s_r.timeout)
    else $error("timeout while disabled");
  a_reserved_ratio: assert property (@(posedge clk_sys) disable iff (reset)
    s_r.ctrl.period_select > 5'h12 |-> ratio == 25'd32)
    else $error("reserved code ratio");
  a_max_ratio: assert property (@(posedge clk_sys) disable iff (reset)
    s_r.ctrl.period_select == 5'h12 |-> ratio == 25'd8388608)
    else $error("max code ratio");
  a_min_ratio: assert property (@(posedge clk_sys) disable iff (reset)
    s_r.ctrl.period_select == 5'h00 |-> ratio == 25'd32)
    else $error("min code ratio");
  a_ratio_double: assert property (@(posedge clk_sys) disable iff (reset)
    s_r.ctrl.period_select == 5'h0f |-> ratio == 25'd1048576)
    else $error("code 01111 ratio");
  a_upper_zero: assert property (@(posedge clk_sys) disable iff (reset)
    !s_r.waitreq && $past(avs_read) && avs_address == 4'h0 |-> avs_readdata[7:6] == 2'b00)
    else $error("unimplemented bits read nonzero");
  a_timeout_cause: assert property (@(posedge clk_sys) disable iff (reset)
    s_r.timeout |-> $past(s_r.osc_tick) && $past(active))
    else $error("timeout without tick");
  a_irq_level: assert property (@(posedge clk_sys) disable iff (reset)
    s_r.timeout && s_r.mask |-> s_r.status ##0 irq)
    else $error("irq not raised");
  c_timeout: cover property (@(posedge clk_sys) s_r.timeout);
  c_ctrl_write: cover property (@(posedge clk_sys) avs_write && !avs_waitrequest);
  c_irq: cover property (@(posedge clk_sys) irq);
endmodule

// ===== test/wpc_top_bench.sv
`timescale 1ns/1ns
module wpc_top_bench;
  localparam int TDIV = 2;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [1:0] watchdog_config_mode = 2'h1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic watchdog_timeout;
  logic irq;
  logic [31:0] rd;
  logic [31:0] seed = 32'h0000_0033;
  logic [4:0] codes [7] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h13, 5'h1f, 5'h13};
  int fail_count = 0;
  int checked = 0;
  int n;
  always #50 clk_sys = ~clk_sys;
  wpc_top #(.TICK_DIV(TDIV)) i_wpc_top (.clk_sys(clk_sys), .reset(reset),
    .watchdog_config_mode(watchdog_config_mode), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .watchdog_timeout(watchdog_timeout), .irq(irq));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // clock cycles to time-out (ticks times TDIV); reserved codes fall back to the shortest ratio
  function automatic int cycles_for(input logic [4:0] c);
    return ((c > wpc_pkg::PS_MAX_CODE) ? 32 : (32 << c)) * TDIV;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("mismatches=%0d comparisons=%0d", fail_count, checked);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // request held until waitrequest is seen low, released after that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    // waitrequest and readdata are sampled at the rising edge itself
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // control write clears the count; tick phase gives a little slack
  task automatic run_to(input logic [31:0] ctl, input int lim);
    bus(1'b1, wpc_pkg::ADDR_CONTROL, ctl);
    n = 0;
    while (watchdog_timeout !== 1'b1 && n < lim) begin
      @(negedge clk_sys);
      n++;
    end
  endtask
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk_sys);
    watchdog_config_mode <= m;
  endtask
  initial begin
    #(100 * 20000);
    fail_count++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    bus(1'b0, wpc_pkg::ADDR_CONTROL, 32'h0000_0000);
    check(rd, 32'h0000_0016);
    bus(1'b1, wpc_pkg::ADDR_CONTROL, 32'hffff_ffff);
    bus(1'b0, wpc_pkg::ADDR_CONTROL, 32'h0000_0000);
    check(rd, 32'h0000_003f);
    bus(1'b0, 4'h2, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    repeat (6) begin
      seed = xorshift(seed);
      bus(1'b1, wpc_pkg::ADDR_CONTROL, seed);
      bus(1'b0, wpc_pkg::ADDR_CONTROL, 32'h0000_0000);
      check(rd, seed & 32'h0000_003f);
    end
    codes[6] = 5'h13 + 5'(seed % 13);
    foreach (codes[i]) begin
      run_to({26'h0, codes[i], 1'b1}, 2000);
      check(32'(n >= cycles_for(codes[i]) - 6 && n <= cycles_for(codes[i]) + 6), 1);
    end
    run_to({26'h0, 5'h12, 1'b1}, 3000);
    check(32'(n), 32'd3000);
    set_mode(wpc_pkg::MODE_OFF);
    run_to(32'h0000_0001, 300);
    check(32'(n), 32'd300);
    bus(1'b0, wpc_pkg::ADDR_COUNT, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    set_mode(wpc_pkg::MODE_SW);
    run_to(32'h0000_0000, 300);
    check(32'(n), 32'd300);
    set_mode(2'h2);
    run_to(32'h0000_0000, 300);
    check(32'(n >= 58 && n <= 70), 1);
    bus(1'b0, wpc_pkg::ADDR_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, wpc_pkg::ADDR_MASK, 32'h0000_0001);
    repeat (2) @(negedge clk_sys);
    check({31'h0, irq}, 32'h0000_0001);
    set_mode(wpc_pkg::MODE_OFF);
    bus(1'b1, wpc_pkg::ADDR_STATUS, 32'h0000_0001);
    bus(1'b0, wpc_pkg::ADDR_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    bus(1'b0, wpc_pkg::ADDR_CONTROL, 32'h0000_0000);
    check(rd, 32'h0000_0016);
    finish_test();
  end
endmodule
